// ---- design/cspt_pkg.sv ----
// types shared by the stack pointer design
// assumes nothing beyond a systemverilog compiler
package cspt_pkg;
  // stack operation requested by the sequencer
  typedef enum logic [2:0] {
    CSPT_OP_NONE,
    CSPT_OP_PUSH,
    CSPT_OP_POP,
    CSPT_OP_CALL,
    CSPT_OP_RET,
    CSPT_OP_IRQ,
    CSPT_OP_IRET
  } cspt_op_e;
  // sequencer of multi byte frames
  typedef enum logic [1:0] {
    CSPT_ST_IDLE,
    CSPT_ST_SAVE,
    CSPT_ST_RESTORE
  } cspt_state_e;
endpackage

// ---- design/cspt_ram.sv ----
// 256 byte stack memory, synchronous write and combinational read sharing one address port
// assumes synchronous write on clk_sys_i gated by the clock enable
`timescale 1ns/1ps
`default_nettype none
`include "cspt_regs.svh"
module cspt_ram
(
  input wire logic clk_sys_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_ff [0:`CSPT_STACK_DEPTH-1];

  // write port
  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i && wr_i)
    begin
      mem_ff[addr_i] <= wdata_i;
    end
  end

  // read port
  assign rdata_o = mem_ff[addr_i];
endmodule
`default_nettype wire

// ---- design/cspt_regs.svh ----
// constants of the cpu stack pointer: reset value, fixed page, frame sizes
// assumes inclusion by bare name from design files
`ifndef CSPT_REGS_SVH
`define CSPT_REGS_SVH
`define CSPT_SP_RESET 16'h01FF
`define CSPT_SP_PAGE 8'h01
`define CSPT_SP_LOW_RESET 8'hFF
`define CSPT_CALL_BYTES 3'h2
`define CSPT_IRQ_BYTES 3'h5
`define CSPT_STACK_DEPTH 256
`endif

// ---- design/cspt_stack_pointer.sv ----
// cpu stack pointer with its 256 byte stack memory
// assumes the sequencer holds op_i until op_done_o for multi byte frames
// Notes on behaviour
// - pointer is 16 bits and addresses the next free stack byte
// - push writes at pointer then decrements; pop increments then reads
// - stack is 256 bytes; upper byte forced to 0x01
// - reset or stack reset instruction loads 0x01FF
// - load instruction reads and writes the pointer low byte directly
// - decrement and increment wrap silently across stack limits
// - interrupt entry stores program counter low byte first, then context
// - call uses two locations, interrupt entry five
// - interrupt return increments and restores context in reverse order
// - explicit push and pop share the pointer behaviour
`timescale 1ns/1ps
`default_nettype none
`include "cspt_regs.svh"
module cspt_stack_pointer
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] op_i,
  input wire logic [7:0] push_data_i,
  input wire logic [39:0] frame_i,
  input wire logic stack_reset_instruction_i,
  input wire logic load_instruction_wr_i,
  input wire logic [7:0] load_instruction_data_i,
  output logic op_done_o,
  output logic [7:0] pop_data_o,
  output logic [39:0] frame_o,
  output logic [15:0] stack_pointer_o,
  output logic [7:0] pointer_low_o
);
  logic [7:0] sp_low_ff;
  logic [7:0] nxt_sp_low;
  cspt_pkg::cspt_state_e state_ff;
  cspt_pkg::cspt_state_e nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [2:0] len_ff;
  logic [2:0] nxt_len;
  logic [7:0] pop_data_ff;
  logic [39:0] frame_ff;
  logic [39:0] frame_in_ff;
  logic [39:0] nxt_frame_in;
  logic mem_wr;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] sp_dec;
  logic [7:0] sp_inc;
  logic done;
  cspt_pkg::cspt_op_e op;

  assign op = cspt_pkg::cspt_op_e'(op_i);
  // 8 bit arithmetic wraps at the stack limits with no flag
  assign sp_dec = sp_low_ff - 8'h01;
  assign sp_inc = sp_low_ff + 8'h01;

  // stack memory
  cspt_ram u_ram
  (
    .clk_sys_i(clk_sys_i),
    .ce_i(ce_i),
    .wr_i(mem_wr),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // operation sequencing and pointer next value
  always_comb
  begin
    nxt_sp_low = sp_low_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_len = len_ff;
    nxt_frame_in = frame_in_ff;
    mem_wr = 1'b0;
    mem_addr = sp_low_ff;
    mem_wdata = push_data_i;
    done = 1'b0;
    case (state_ff)
      cspt_pkg::CSPT_ST_IDLE:
      begin
        if (stack_reset_instruction_i)
        begin
          nxt_sp_low = `CSPT_SP_LOW_RESET;
          done = 1'b1;
        end
        else if (load_instruction_wr_i)
        begin
          nxt_sp_low = load_instruction_data_i;
          done = 1'b1;
        end
        else
        begin
          case (op)
            cspt_pkg::CSPT_OP_PUSH:
            begin
              // write at pointer, then step down
              mem_wr = 1'b1;
              nxt_sp_low = sp_dec;
              done = 1'b1;
            end
            cspt_pkg::CSPT_OP_POP:
            begin
              // step up first; data read next cycle at new pointer
              nxt_sp_low = sp_inc;
              nxt_state = cspt_pkg::CSPT_ST_RESTORE;
              nxt_len = 3'h1;
              nxt_cnt = 3'h0;
            end
            cspt_pkg::CSPT_OP_CALL, cspt_pkg::CSPT_OP_IRQ:
            begin
              nxt_state = cspt_pkg::CSPT_ST_SAVE;
              nxt_len = (op == cspt_pkg::CSPT_OP_CALL) ?
                `CSPT_CALL_BYTES : `CSPT_IRQ_BYTES;
              nxt_cnt = 3'h0;
              nxt_frame_in = frame_i;
            end
            cspt_pkg::CSPT_OP_RET, cspt_pkg::CSPT_OP_IRET:
            begin
              nxt_sp_low = sp_inc;
              nxt_state = cspt_pkg::CSPT_ST_RESTORE;
              nxt_len = (op == cspt_pkg::CSPT_OP_RET) ?
                `CSPT_CALL_BYTES : `CSPT_IRQ_BYTES;
              nxt_cnt = 3'h0;
            end
            default:
            begin
              nxt_state = cspt_pkg::CSPT_ST_IDLE;
            end
          endcase
        end
      end
      cspt_pkg::CSPT_ST_SAVE:
      begin
        // byte 0 of frame is program counter low byte, stored first
        mem_wr = 1'b1;
        mem_wdata = frame_in_ff[7:0];
        nxt_frame_in = {8'h00, frame_in_ff[39:8]};
        nxt_sp_low = sp_dec;
        nxt_cnt = cnt_ff + 3'h1;
        if (nxt_cnt == len_ff)
        begin
          nxt_state = cspt_pkg::CSPT_ST_IDLE;
          done = 1'b1;
        end
      end
      cspt_pkg::CSPT_ST_RESTORE:
      begin
        // last saved byte comes back first, reversing entry order
        nxt_cnt = cnt_ff + 3'h1;
        if (nxt_cnt == len_ff)
        begin
          nxt_state = cspt_pkg::CSPT_ST_IDLE;
          done = 1'b1;
        end
        else
        begin
          nxt_sp_low = sp_inc;
        end
      end
      default:
      begin
        nxt_state = cspt_pkg::CSPT_ST_IDLE;
      end
    endcase
  end

  // pointer low byte register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sp_low_ff <= `CSPT_SP_LOW_RESET;
    end
    else if (ce_i)
    begin
      sp_low_ff <= nxt_sp_low;
    end
  end

  // state, counters and saved frame
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= cspt_pkg::CSPT_ST_IDLE;
      cnt_ff <= 3'h0;
      len_ff <= 3'h0;
      frame_in_ff <= 40'h00_0000_0000;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      len_ff <= nxt_len;
      frame_in_ff <= nxt_frame_in;
    end
  end

  // popped data capture; restored frame rebuilt low byte last
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pop_data_ff <= 8'h00;
      frame_ff <= 40'h00_0000_0000;
    end
    else if (ce_i && state_ff == cspt_pkg::CSPT_ST_RESTORE)
    begin
      pop_data_ff <= mem_rdata;
      frame_ff <= {frame_ff[31:0], mem_rdata};
    end
  end

  // outputs; upper byte is constant
  assign stack_pointer_o = {`CSPT_SP_PAGE, sp_low_ff};
  assign pointer_low_o = sp_low_ff;
  assign pop_data_o = pop_data_ff;
  assign frame_o = frame_ff;
  assign op_done_o = done & ce_i;
endmodule
`default_nettype wire

// ---- dv/cspt_monitor.sv ----
// checker of pointer moves seen at the stack pointer ports
// assumes it is bound onto cspt_stack_pointer
`timescale 1ns/1ps
`default_nettype none
module cspt_monitor
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] op_i,
  input wire logic stack_reset_instruction_i,
  input wire logic load_instruction_wr_i,
  input wire logic [7:0] load_instruction_data_i,
  input wire logic op_done_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic [7:0] pointer_low_o
);
  logic first_ff;
  logic [7:0] start_ff;
  logic [7:0] st;
  logic idle;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // low byte from the first cycle of the running operation
  assign st = first_ff ? pointer_low_o : start_ff;
  assign idle = ce_i && op_i == 3'h0;
  // marks the cycle where a new operation may start
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) first_ff <= 1'b1;
    else if (ce_i) first_ff <= op_done_o || op_i == 3'h0;
  // keeps the starting low byte
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) start_ff <= 8'hFF;
    else if (ce_i) start_ff <= st;
  a_page_fixed: assert property (stack_pointer_o[15:8] == 8'h01)
    else $error("page byte moved");
  a_low_mirror: assert property (stack_pointer_o[7:0] == pointer_low_o)
    else $error("low byte differs");
  a_push_step: assert property (op_i == 3'h1 && op_done_o
    |=> pointer_low_o == $past(pointer_low_o) - 8'h01) else $error("push");
  a_call_size: assert property (op_i == 3'h3 && op_done_o
    |=> pointer_low_o == $past(st) - 8'h02) else $error("call size");
  a_irq_size: assert property (op_i == 3'h5 && op_done_o
    |=> pointer_low_o == $past(st) - 8'h05) else $error("irq size");
  a_iret_size: assert property (op_i == 3'h6 && op_done_o
    |=> pointer_low_o == $past(st) + 8'h05) else $error("iret size");
  a_stk_reset: assert property (idle && stack_reset_instruction_i
    |=> stack_pointer_o == 16'h01FF) else $error("stack reset");
  a_load_low: assert property (idle && load_instruction_wr_i &&
    !stack_reset_instruction_i |=> pointer_low_o ==
    $past(load_instruction_data_i)) else $error("load");
  c_irq: cover property (op_i == 3'h5 && op_done_o);
  c_iret: cover property (op_i == 3'h6 && op_done_o);
  c_wrap: cover property (op_i == 3'h2 ##1 pointer_low_o == 8'h00);
endmodule
bind cspt_stack_pointer cspt_monitor u_mon (.clk_sys_i, .rst_i, .ce_i,
  .op_i, .stack_reset_instruction_i, .load_instruction_wr_i,
  .load_instruction_data_i, .op_done_o, .stack_pointer_o, .pointer_low_o);
`default_nettype wire

// ---- dv/cspt_seq_model.sv ----
// sequencer model: latches a command, holds it until done
// assumes done is sampled on the rising edge
`timescale 1ns/1ps
`default_nettype none
module cspt_seq_model
(
  input wire logic clk_i,
  input wire logic [2:0] cmd_i,
  input wire logic op_done_i,
  output logic [2:0] op_o
);
  logic fin_ff = 1'b0;
  initial op_o = 3'h0;
  // note completion at the sampling edge
  always @(posedge clk_i)
    fin_ff <= op_done_i && op_o != 3'h0;
  // launch and release away from the sampling edge
  always @(negedge clk_i)
    if (fin_ff) op_o <= 3'h0;
    else if (op_o == 3'h0) op_o <= cmd_i;
endmodule
`default_nettype wire

// ---- dv/tb_cpu_stack_pointer.sv ----
// self checking bench of the stack pointer
// assumes design, checker and sequencer model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_stack_pointer;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] cmd = 3'h0;
  logic [2:0] op;
  logic done;
  logic [7:0] pd = 8'h00;
  logic [39:0] fr = 40'h0;
  logic srst = 1'b0;
  logic ldw = 1'b0;
  logic [7:0] ldd = 8'h00;
  logic [7:0] pop_d;
  logic [39:0] fr_o;
  logic [15:0] sp;
  logic [7:0] pl;
  logic ce = 1'b1;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  // free running clock
  always #10 clk_sys_i = ~clk_sys_i;
  cspt_stack_pointer dut (.clk_sys_i, .rst_i, .ce_i(ce), .op_i(op),
    .push_data_i(pd), .frame_i(fr), .stack_reset_instruction_i(srst),
    .load_instruction_wr_i(ldw), .load_instruction_data_i(ldd),
    .op_done_o(done), .pop_data_o(pop_d), .frame_o(fr_o),
    .stack_pointer_o(sp), .pointer_low_o(pl));
  cspt_seq_model seq (.clk_i(clk_sys_i), .cmd_i(cmd), .op_done_i(done),
    .op_o(op));
  // compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_sp(input logic [15:0] e);
    chk({24'h0, sp}, {24'h0, e});
    chk({32'h0, pl}, {32'h0, e[7:0]});
  endtask
  // hand one operation to the sequencer and wait for its release
  task automatic run(input logic [2:0] c);
    @(negedge clk_sys_i) cmd <= c;
    for (int i = 0; i < 9 && op === 3'h0; i++) @(posedge clk_sys_i);
    @(negedge clk_sys_i) cmd <= 3'h0;
    for (int i = 0; i < 9 && op !== 3'h0; i++) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  // one cycle strobe: stack reset or low byte load
  task automatic strobe(input logic rs, input logic [7:0] d);
    @(negedge clk_sys_i);
    srst <= rs;
    ldw <= !rs;
    ldd <= d;
    @(negedge clk_sys_i);
    srst <= 1'b0;
    ldw <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic t_push_pop();
    pd = 8'hA5;
    run(3'h1);
    chk_sp(16'h01FE);
    pd = 8'h5A;
    run(3'h1);
    run(3'h2);
    chk({32'h0, pop_d}, 40'h5A);
    chk_sp(16'h01FE);
    run(3'h2);
    chk({32'h0, pop_d}, 40'hA5);
    $display("test push_pop done");
  endtask
  task automatic t_wrap();
    run(3'h2);
    chk_sp(16'h0100);
    run(3'h1);
    chk_sp(16'h01FF);
    $display("test wrap done");
  endtask
  task automatic t_call();
    fr = 40'h0000001234;
    run(3'h3);
    chk_sp(16'h01FD);
    fr = 40'h0;
    run(3'h4);
    chk({24'h0, fr_o[15:0]}, 40'h1234);
    $display("test call done");
  endtask
  task automatic t_irq();
    fr = 40'h1122334455;
    run(3'h5);
    chk_sp(16'h01FA);
    strobe(1'b0, 8'hFA);
    run(3'h6);
    chk(fr_o, 40'h1122334455);
    chk_sp(16'h01FF);
    strobe(1'b0, 8'hFE);
    run(3'h2);
    chk({32'h0, pop_d}, 40'h55);
    $display("test irq done");
  endtask
  task automatic t_load();
    strobe(1'b0, 8'h3C);
    chk_sp(16'h013C);
    strobe(1'b1, 8'h00);
    chk_sp(16'h01FF);
    // clock enable low freezes the pointer against a load strobe
    @(negedge clk_sys_i);
    ce <= 1'b0;
    strobe(1'b0, 8'h55);
    chk_sp(16'h01FF);
    ce <= 1'b1;
    @(negedge clk_sys_i);
    $display("test load done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  // main sequence
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    rst_i <= 1'b0;
    chk_sp(16'h01FF);
    t_push_pop();
    t_wrap();
    t_call();
    t_irq();
    t_load();
    print_verdict();
  end
endmodule
`default_nettype wire
